/* common/pmr_result_regs_map.svh */
`ifndef PMR_RESULT_REGS_MAP_SVH
`define PMR_RESULT_REGS_MAP_SVH

// ---------------------------------------------------------------
// register offsets
// ---------------------------------------------------------------
`define PMR_CFG_ADDR 8'h00
`define PMR_SHUNT_ADDR 8'h01
`define PMR_BUS_ADDR 8'h02
`define PMR_POWER_ADDR 8'h03
`define PMR_CURRENT_ADDR 8'h04
`define PMR_CAL_ADDR 8'h05

// ---------------------------------------------------------------
// configuration fields and reset values
// ---------------------------------------------------------------
`define PMR_CFG_RST_BIT 15
`define PMR_AVG_MSB 11
`define PMR_AVG_LSB 9
`define PMR_BUSCT_MSB 8
`define PMR_BUSCT_LSB 6
`define PMR_SHCT_MSB 5
`define PMR_SHCT_LSB 3
`define PMR_MODE_CONT_BIT 2
`define PMR_MODE_BUS_BIT 1
`define PMR_MODE_SHUNT_BIT 0
`define PMR_CFG_RST 16'h4127
`define PMR_CFG_WMASK 16'h7FFF
`define PMR_CAL_RST 15'h0000
`define PMR_RESULT_RST 16'h0000

// ---------------------------------------------------------------
// timing, in ns, and cycle counts at the core clock
// ---------------------------------------------------------------
`define PMR_CLK_NS 8
`define PMR_CT0_NS 140000
`define PMR_CT1_NS 204000
`define PMR_CT2_NS 332000
`define PMR_CT3_NS 588000
`define PMR_CT4_NS 1100000
`define PMR_CT5_NS 2116000
`define PMR_CT6_NS 4156000
`define PMR_CT7_NS 8244000
`define PMR_CYC(ns) ((ns) / `PMR_CLK_NS)

// ---------------------------------------------------------------
// result scaling
// ---------------------------------------------------------------
`define PMR_CUR_SHIFT 11
`define PMR_PWR_DIV 20000

`endif

/* common/pmr_pkg.sv */
package pmr_pkg;

    typedef enum logic [2:0] {
        PMR_IDLE,
        PMR_START,
        PMR_SHUNT,
        PMR_BUS,
        PMR_CALC_C,
        PMR_CALC_P
    } pmr_state_t;

    typedef struct packed {
        pmr_state_t state;
        logic [15:0] cfg;
        logic [14:0] cal;
        logic [15:0] shunt;
        logic [15:0] bus;
        logic [15:0] cur;
        logic [15:0] pwr;
        logic [20:0] timer;
        logic [10:0] samp;
        logic [25:0] acc_sh;
        logic [24:0] acc_bus;
        logic [15:0] rd_data;
        logic sh_act;
        logic bus_act;
    } pmr_regs_t;

endpackage

/* verilog/pmr_result_regs.sv */
// Functional notes
// - shunt conversion time chosen by 3-bit code, 140us up to 8.244ms
// - mode codes 001/010/011 triggered, 101/110/111 continuous, per channel set
// - mode 000 or 100 powers down, no measurements
// - shunt result is 16-bit two's complement, zero after power-on
// - shunt result scaled 2.5uV per count, 7FFF is 81.9175mV
// - with averaging the shunt result shows the averaged value
// - bus result holds latest reading in bits 14..0, top bit zero
// - bus result scaled 1.25mV per count, 7FFF is 40.95875V
// - with averaging the bus result shows the averaged value
// - power step is 25 times the current step
// - power result is current times bus voltage in power steps
// - with averaging current and power are averaged values
// - current result is calibration times shunt result, divided by 2048, signed
// - calibration holds 15 writable bits, top bit zero, resets to zero
// - calibration sets current and power resolution
// - configuration write aborts conversion and restarts with new settings
// - averaging code selects 1,4,16,64,128,256,512 or 1024 samples
`include "pmr_result_regs_map.svh"

module pmr_result_regs #(
    parameter logic [7:0][20:0] CONV_CYCLES = {
        21'(`PMR_CYC(`PMR_CT7_NS)), 21'(`PMR_CYC(`PMR_CT6_NS)),
        21'(`PMR_CYC(`PMR_CT5_NS)), 21'(`PMR_CYC(`PMR_CT4_NS)),
        21'(`PMR_CYC(`PMR_CT3_NS)), 21'(`PMR_CYC(`PMR_CT2_NS)),
        21'(`PMR_CYC(`PMR_CT1_NS)), 21'(`PMR_CYC(`PMR_CT0_NS))
    }
) (
    input wire logic clk, // core clock
    input wire logic reset_n, // synchronous reset
    input wire logic [7:0] reg_addr, // register pointer
    input wire logic [15:0] reg_wdata, // write data
    input wire logic reg_wr, // write strobe
    input wire logic reg_rd, // read strobe
    input wire logic [15:0] adc_shunt_code, // shunt sample, two's complement
    input wire logic [14:0] adc_bus_code, // bus sample
    output logic [15:0] rd_data, // read data, one cycle after reg_rd
    output logic shunt_conv_active, // shunt channel converting
    output logic bus_conv_active // bus channel converting
);

    // ---------------------------------------------------------------
    // state
    // ---------------------------------------------------------------
    pmr_pkg::pmr_regs_t st;
    pmr_pkg::pmr_regs_t next_st;

    logic cfg_wr;
    logic cal_wr;
    logic [3:0] avg_shift;
    logic [2:0] shct;
    logic [2:0] busct;
    logic [31:0] cur_prod;
    logic [15:0] cur_mag;
    logic [30:0] pwr_prod;
    logic [30:0] pwr_quot;
    logic last_samp;

    assign cfg_wr = reg_wr && (reg_addr == `PMR_CFG_ADDR);
    assign cal_wr = reg_wr && (reg_addr == `PMR_CAL_ADDR);
    assign shct = st.cfg[`PMR_SHCT_MSB:`PMR_SHCT_LSB];
    assign busct = st.cfg[`PMR_BUSCT_MSB:`PMR_BUSCT_LSB];
    assign last_samp = (st.samp == 11'h000);

    // the current product keeps the sign of the shunt; cal is never negative
    assign cur_prod = 32'($signed(st.shunt) * $signed({1'b0, st.cal}));
    assign cur_mag = st.cur[15] ? 16'(-st.cur) : st.cur;
    assign pwr_prod = 31'(cur_mag * st.bus[14:0]);
    // dividing by the step ratio folds the 25x power step into the result
    assign pwr_quot = pwr_prod / 31'(`PMR_PWR_DIV);

    always_comb
    begin
        case (st.cfg[`PMR_AVG_MSB:`PMR_AVG_LSB])
            3'h0: avg_shift = 4'h0;
            3'h1: avg_shift = 4'h2;
            3'h2: avg_shift = 4'h4;
            3'h3: avg_shift = 4'h6;
            3'h4: avg_shift = 4'h7;
            3'h5: avg_shift = 4'h8;
            3'h6: avg_shift = 4'h9;
            default: avg_shift = 4'hA;
        endcase
    end

    // ---------------------------------------------------------------
    // next state
    // ---------------------------------------------------------------
    always_comb
    begin
        next_st = st;
        next_st.rd_data = `PMR_RESULT_RST;
        if (reg_rd)
        begin
            case (reg_addr)
                `PMR_CFG_ADDR: next_st.rd_data = st.cfg;
                `PMR_SHUNT_ADDR: next_st.rd_data = st.shunt;
                `PMR_BUS_ADDR: next_st.rd_data = st.bus;
                `PMR_POWER_ADDR: next_st.rd_data = st.pwr;
                `PMR_CURRENT_ADDR: next_st.rd_data = st.cur;
                `PMR_CAL_ADDR: next_st.rd_data = {1'b0, st.cal};
                default: next_st.rd_data = `PMR_RESULT_RST;
            endcase
        end

        case (st.state)
            pmr_pkg::PMR_IDLE:
            begin
                next_st.state = pmr_pkg::PMR_IDLE;
            end
            pmr_pkg::PMR_START:
            begin
                next_st.acc_sh = 26'h0;
                next_st.acc_bus = 25'h0;
                next_st.samp = 11'((11'h001 << avg_shift) - 11'h001);
                if (st.cfg[`PMR_MODE_SHUNT_BIT])
                begin
                    next_st.state = pmr_pkg::PMR_SHUNT;
                    next_st.timer = 21'(CONV_CYCLES[shct] - 21'h1);
                end
                else if (st.cfg[`PMR_MODE_BUS_BIT])
                begin
                    next_st.state = pmr_pkg::PMR_BUS;
                    next_st.timer = 21'(CONV_CYCLES[busct] - 21'h1);
                end
                else
                begin
                    next_st.state = pmr_pkg::PMR_IDLE;
                end
            end
            pmr_pkg::PMR_SHUNT:
            begin
                next_st.timer = 21'(st.timer - 21'h1);
                if (st.timer == 21'h0)
                begin
                    next_st.acc_sh = 26'($signed(st.acc_sh) + $signed(adc_shunt_code));
                    if (st.cfg[`PMR_MODE_BUS_BIT])
                    begin
                        next_st.state = pmr_pkg::PMR_BUS;
                        next_st.timer = 21'(CONV_CYCLES[busct] - 21'h1);
                    end
                    else if (last_samp)
                    begin
                        next_st.state = pmr_pkg::PMR_CALC_C;
                        // averaged value replaces the single sample
                        next_st.shunt = 16'($signed(next_st.acc_sh) >>> avg_shift);
                    end
                    else
                    begin
                        next_st.samp = 11'(st.samp - 11'h001);
                        next_st.timer = 21'(CONV_CYCLES[shct] - 21'h1);
                    end
                end
            end
            pmr_pkg::PMR_BUS:
            begin
                next_st.timer = 21'(st.timer - 21'h1);
                if (st.timer == 21'h0)
                begin
                    next_st.acc_bus = 25'(st.acc_bus + 25'(adc_bus_code));
                    if (last_samp)
                    begin
                        next_st.state = pmr_pkg::PMR_CALC_C;
                        next_st.bus = {1'b0, 15'(next_st.acc_bus >> avg_shift)};
                        if (st.cfg[`PMR_MODE_SHUNT_BIT])
                        begin
                            next_st.shunt = 16'($signed(st.acc_sh) >>> avg_shift);
                        end
                    end
                    else if (st.cfg[`PMR_MODE_SHUNT_BIT])
                    begin
                        next_st.samp = 11'(st.samp - 11'h001);
                        next_st.state = pmr_pkg::PMR_SHUNT;
                        next_st.timer = 21'(CONV_CYCLES[shct] - 21'h1);
                    end
                    else
                    begin
                        next_st.samp = 11'(st.samp - 11'h001);
                        next_st.timer = 21'(CONV_CYCLES[busct] - 21'h1);
                    end
                end
            end
            pmr_pkg::PMR_CALC_C:
            begin
                // derived from averaged inputs, so it is itself averaged
                next_st.cur = 16'($signed(cur_prod) >>> `PMR_CUR_SHIFT);
                next_st.state = pmr_pkg::PMR_CALC_P;
            end
            pmr_pkg::PMR_CALC_P:
            begin
                next_st.pwr = 16'(pwr_quot);
                if (st.cfg[`PMR_MODE_CONT_BIT])
                begin
                    next_st.state = pmr_pkg::PMR_START;
                end
                else
                begin
                    next_st.state = pmr_pkg::PMR_IDLE;
                end
            end
            default:
            begin
                next_st.state = pmr_pkg::PMR_IDLE;
            end
        endcase

        if (cal_wr)
        begin
            next_st.cal = reg_wdata[14:0];
        end
        if (cfg_wr)
        begin
            if (reg_wdata[`PMR_CFG_RST_BIT])
            begin
                next_st.cfg = `PMR_CFG_RST;
                next_st.cal = `PMR_CAL_RST;
                next_st.shunt = `PMR_RESULT_RST;
                next_st.bus = `PMR_RESULT_RST;
                next_st.cur = `PMR_RESULT_RST;
                next_st.pwr = `PMR_RESULT_RST;
            end
            else
            begin
                next_st.cfg = reg_wdata & `PMR_CFG_WMASK;
            end
            // partial accumulations are dropped so no sample mixes settings
            next_st.state = pmr_pkg::PMR_START;
        end
        next_st.sh_act = (next_st.state == pmr_pkg::PMR_SHUNT);
        next_st.bus_act = (next_st.state == pmr_pkg::PMR_BUS);
    end

    // ---------------------------------------------------------------
    // registers
    // ---------------------------------------------------------------
    always_ff @(posedge clk)
    begin
        if (!reset_n)
        begin
            st <= '{state: pmr_pkg::PMR_START, cfg: `PMR_CFG_RST, default: '0};
        end
        else
        begin
            st <= next_st;
        end
    end

    assign rd_data = st.rd_data;
    assign shunt_conv_active = st.sh_act;
    assign bus_conv_active = st.bus_act;

    // ---------------------------------------------------------------
    // assertions
    // ---------------------------------------------------------------
    default clocking cb @(posedge clk);
    endclocking
    default disable iff (!reset_n);

    sequence cal_write_s;
        cal_wr ##1 (reg_rd && reg_addr == `PMR_CAL_ADDR);
    endsequence

    sequence done_trig_s;
        st.state == pmr_pkg::PMR_CALC_P && !st.cfg[`PMR_MODE_CONT_BIT] && !cfg_wr;
    endsequence

    shunt_time_load_a: assert property ($rose(shunt_conv_active) |->
        st.timer == 21'(CONV_CYCLES[shct] - 21'h1))
        else $error("shunt conversion time not loaded from select");
    mode_channel_a: assert property ((!st.cfg[`PMR_MODE_SHUNT_BIT] |-> !shunt_conv_active)
        and (!st.cfg[`PMR_MODE_BUS_BIT] |-> !bus_conv_active))
        else $error("unselected channel converting");
    // a later write may restart the machine, which is no breach of power-down
    power_down_a: assert property ((st.cfg[1:0] == 2'b00 && !cfg_wr) |=>
        !shunt_conv_active && !bus_conv_active
        ##1 (st.state == pmr_pkg::PMR_IDLE || $past(cfg_wr)))
        else $error("conversion in power-down");
    bus_top_zero_a: assert property (st.bus[15] == 1'b0)
        else $error("bus result top bit set");
    cal_readback_a: assert property (cal_write_s |=>
        rd_data == ($past(reg_wdata, 2) & `PMR_CFG_WMASK))
        else $error("calibration readback wrong");
    cfg_abort_a: assert property (cfg_wr |=> st.state == pmr_pkg::PMR_START
        && !shunt_conv_active && !bus_conv_active)
        else $error("configuration write did not abort");
    trig_idle_a: assert property (done_trig_s |=> st.state == pmr_pkg::PMR_IDLE
        ##1 (st.state == pmr_pkg::PMR_IDLE || $past(cfg_wr)))
        else $error("triggered mode did not idle");
    current_calc_a: assert property ((st.state == pmr_pkg::PMR_CALC_C && !cfg_wr) |=>
        st.cur == 16'($signed($past(cur_prod)) >>> `PMR_CUR_SHIFT)
        ##1 (cfg_wr || $past(cfg_wr) || st.pwr == 16'($past(pwr_quot))))
        else $error("current or power not recomputed");
    sample_count_a: assert property ((st.state == pmr_pkg::PMR_START && !cfg_wr
        && st.cfg[1:0] != 2'b00) |=>
        st.samp == 11'((11'h001 << $past(avg_shift)) - 11'h001))
        else $error("averaging count wrong");

    sequence cfg_restart_s;
        cfg_wr ##1 (st.cfg[1:0] != 2'b00 && !cfg_wr);
    endsequence

    cal_store_a: assert property (cal_wr |=>
        {1'b0, st.cal} == ($past(reg_wdata) & 16'h7FFF))
        else $error("calibration write not stored");
    restart_conv_a: assert property (cfg_restart_s |=>
        shunt_conv_active || bus_conv_active)
        else $error("no fresh conversion after configuration write");

endmodule

/* tb/pmr_adc_model.sv */
module pmr_adc_model (
    input wire logic shunt_conv_active, // shunt converting
    input wire logic bus_conv_active, // bus converting
    input wire logic [15:0] shunt_val, // shunt level to present
    input wire logic [14:0] bus_val, // bus level to present
    output logic [15:0] adc_shunt_code, // to design
    output logic [14:0] adc_bus_code // to design
);
    timeunit 1ns;
    timeprecision 1ps;
    // outside a conversion the code is inverted, so a mistimed sample shows up
    assign adc_shunt_code = shunt_conv_active ? shunt_val : ~shunt_val;
    assign adc_bus_code = bus_conv_active ? bus_val : ~bus_val;
endmodule

/* tb/testbench.sv */
module testbench;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [7:0][20:0] CONV = {21'h28, 21'h23, 21'h1E, 21'h19, 21'h14, 21'hF,
        21'hA, 21'h5};
    logic clk = 1'b0;
    logic reset_n = 1'b0;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic [7:0] reg_addr = 8'h00;
    logic [15:0] reg_wdata = 16'h0000;
    logic [15:0] shunt_val = 16'h0000;
    logic [14:0] bus_val = 15'h0000;
    logic [15:0] rd_data, adc_shunt_code, exp_sh, exp_bus;
    logic [14:0] adc_bus_code;
    logic shunt_conv_active, bus_conv_active;
    logic [31:0] seed = 32'h72EE;
    logic [15:0] sc = 16'h0000;
    logic [15:0] bc = 16'h0000;
    logic en_len = 1'b0;
    int n_fail = 0;
    int checks_done = 0;
    int cycles = 0;

    pmr_result_regs #(.CONV_CYCLES(CONV)) pmr_result_regs_i (.clk(clk), .reset_n(reset_n),
        .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
        .adc_shunt_code(adc_shunt_code), .adc_bus_code(adc_bus_code), .rd_data(rd_data),
        .shunt_conv_active(shunt_conv_active), .bus_conv_active(bus_conv_active));
    pmr_adc_model pmr_adc_model_i (.shunt_conv_active(shunt_conv_active),
        .bus_conv_active(bus_conv_active), .shunt_val(shunt_val), .bus_val(bus_val),
        .adc_shunt_code(adc_shunt_code), .adc_bus_code(adc_bus_code));

    initial
    begin
        forever #4 clk = ~clk;
    end

    // ---------------------------------------------------------------
    // helpers
    // ---------------------------------------------------------------
    task check(input logic [15:0] seen, input logic [15:0] want);
        checks_done++;
        if (seen !== want)
        begin
            n_fail++;
            $display("Error at %0t ns: seen %h expected %h", $time, seen, want);
        end
    endtask

    task close_out;
        if (n_fail == 0 && checks_done > 0)
            $display("verification passed");
        else
            $display("verification failed");
        $finish;
    endtask

    function logic [31:0] xs(input logic [31:0] x);
        logic [31:0] y;
        y = x ^ (x << 13);
        y = y ^ (y >> 17);
        return y ^ (y << 5);
    endfunction

    function logic [15:0] exp_cur(input logic [15:0] sh, input logic [14:0] cal);
        logic signed [31:0] p;
        p = $signed(sh) * $signed({17'h00000, cal});
        p = p >>> 11;
        return p[15:0];
    endfunction

    function logic [15:0] exp_pwr(input logic [15:0] cur, input logic [15:0] bus);
        logic [16:0] mag;
        logic [32:0] p;
        mag = cur[15] ? 17'h10000 - {1'b0, cur} : {1'b0, cur};
        p = mag * bus;
        p = p / 33'h4E20;
        return p[15:0];
    endfunction

    task wr(input logic [7:0] a, input logic [15:0] d);
        @(posedge clk);
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        @(negedge clk);
    endtask

    task rd(input logic [7:0] a, output logic [15:0] v);
        @(posedge clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        v = rd_data;
    endtask

    // a converter that never moves is reported instead of hanging the run
    task wait_lvl(input logic ch, input logic lvl);
        int t;
        t = 0;
        while ((ch ? bus_conv_active : shunt_conv_active) !== lvl && t < 3000)
        begin
            @(negedge clk);
            t++;
        end
        if (t == 3000)
            check(16'h0000, 16'h0001);
    endtask

    always @(negedge clk)
    begin
        if (en_len && sc != 16'h0000 && shunt_conv_active !== 1'b1)
            check(sc, exp_sh);
        if (en_len && bc != 16'h0000 && bus_conv_active !== 1'b1)
            check(bc, exp_bus);
        sc = shunt_conv_active === 1'b1 ? sc + 16'h0001 : 16'h0000;
        bc = bus_conv_active === 1'b1 ? bc + 16'h0001 : 16'h0000;
    end

    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 60000)
        begin
            n_fail++;
            close_out();
        end
    end

    // ---------------------------------------------------------------
    // main sequence
    // ---------------------------------------------------------------
    initial
    begin
        logic [15:0] v, es, eb, ec;
        logic [14:0] cal;
        longint ssum, bsum;
        int n_sh, n_bus, sh;
        bit ps, pb;
        repeat (20) @(posedge clk);
        reset_n <= 1'b1;
        for (int a = 0; a < 8; a++)
        begin
            rd(8'(a), v);
            check(v, a == 0 ? 16'h4127 : 16'h0000);
        end
        seed = xs(seed);
        cal = seed[14:0] | 15'h0001;
        // write then read on the next edge, the read must see the new value
        @(posedge clk);
        reg_addr <= 8'h05;
        reg_wdata <= {1'b1, ~cal};
        reg_wr <= 1'b1;
        @(posedge clk);
        reg_wr <= 1'b0;
        reg_rd <= 1'b1;
        @(posedge clk);
        reg_rd <= 1'b0;
        @(negedge clk);
        check(rd_data, {1'b0, ~cal});
        wr(8'h05, {1'b1, cal});
        rd(8'h05, v);
        check(v, {1'b0, cal});
        for (int m = 0; m < 8; m++)
        begin
            wr(8'h00, 16'(m));
            n_sh = 0;
            n_bus = 0;
            ps = 0;
            pb = 0;
            repeat (150)
            begin
                @(negedge clk);
                n_sh += int'(shunt_conv_active && !ps);
                n_bus += int'(bus_conv_active && !pb);
                ps = shunt_conv_active;
                pb = bus_conv_active;
            end
            check(16'(n_sh > 1 ? 2 : n_sh), !m[0] ? 16'h0 : m[2] ? 16'h2 : 16'h1);
            check(16'(n_bus > 1 ? 2 : n_bus), !m[1] ? 16'h0 : m[2] ? 16'h2 : 16'h1);
        end
        for (int i = 0; i < 8; i++)
        begin
            wr(8'h00, {4'h0, 3'(i), 3'h0, 3'(7 - i), 3'h3});
            @(negedge clk);
            exp_sh = 16'(CONV[7 - i]);
            exp_bus = 16'(CONV[0]);
            en_len = 1'b1;
            sh = i < 4 ? 2 * i : i + 3;
            ssum = 0;
            bsum = 0;
            repeat (1 << sh)
            begin
                wait_lvl(1'b0, 1'b1);
                seed = xs(seed);
                @(posedge clk);
                shunt_val <= seed[15:0];
                bus_val <= seed[30:16];
                ssum += longint'($signed(seed[15:0]));
                bsum += longint'(seed[30:16]);
                @(negedge clk);
                wait_lvl(1'b1, 1'b1);
                wait_lvl(1'b1, 1'b0);
            end
            repeat (5) @(negedge clk);
            es = 16'(ssum >>> sh);
            eb = 16'(bsum >> sh);
            ec = exp_cur(es, cal);
            rd(8'h01, v);
            check(v, es);
            rd(8'h02, v);
            check(v, eb);
            rd(8'h04, v);
            check(v, ec);
            rd(8'h03, v);
            check(v, exp_pwr(ec, eb));
            en_len = 1'b0;
        end
        wr(8'h00, 16'h0027);
        wait_lvl(1'b0, 1'b1);
        repeat (3) @(negedge clk);
        wr(8'h00, 16'h000F);
        check({14'h0000, shunt_conv_active, bus_conv_active}, 16'h0000);
        @(negedge clk);
        exp_sh = 16'(CONV[1]);
        en_len = 1'b1;
        wait_lvl(1'b0, 1'b1);
        wait_lvl(1'b0, 1'b0);
        @(negedge clk);
        en_len = 1'b0;
        wr(8'h00, 16'h8000);
        for (int a = 0; a < 6; a++)
        begin
            rd(8'(a), v);
            check(v, a == 0 ? 16'h4127 : 16'h0000);
        end
        close_out();
    end
endmodule
